/* hdl/flash_program_erase_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_defines.svh"

// Functional notes
// - Trigger starts the unlock window timer.
// - Six key bytes into data pairs one-three.
// - Window timeout clears trigger whatever was written.
// - Correct key in window sets program enable.
// - Wrong key leaves program enable low.
// - Clearing program enable locks at once.
// - Erase mode plus start erases addressed block.
// - Start stays high about 2.2 ms.
// - Processor stalls while an operation runs.
// - Small variant erases 256-word block, bits 11..8.
// - Small variant writes four words, low bits ignored.
// - Page buffer holds 64 words, page bits 13..6.
// - Each high-byte load advances buffer address.
// - Buffer address saturates at page end.
// - Low byte write only stores the byte.
// - Hardware clears buffer clear bit when done.
module flash_program_erase_sequencer
  import flash_seq_pkg::*;
#(
  parameter bit PAGE_VARIANT = 1'b1,
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic cpu_stall,
  output logic flash_erase,
  output logic flash_wr,
  output logic [`ADDR_W-1:0] flash_addr,
  output logic [15:0] flash_wdata
);
  import flash_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  flash_seq_pkg::seq_state_e state;
  flash_seq_pkg::seq_state_e next_state;
  flash_seq_pkg::op_mode_t mode;
  logic prog_en;
  logic [7:0] addr_low;
  logic [5:0] addr_high;
  logic [7:0] data_lo [0:3];
  logic [7:0] data_hi [0:3];
  logic [15:0] wbuf [0:`PAGE_WORDS-1];
  logic [`PAGE_IDX_W-1:0] op_cnt;
  logic [5:0] key_seen;
  logic key_bad;
  logic win_busy;
  logic prog_busy;
  logic prog_done;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i && wb_sel_i[0];
  wire [7:0] wbyte = wb_dat_i[7:0];
  wire [3:0] widx = wb_adr_i[5:2];
  wire in_map = (wb_adr_i[7:6] == 2'b00) && (wb_adr_i[1:0] == 2'b00)
    && (wb_adr_i[5:0] <= `OFS_LAST);
  wire wr_ctrl = wr && in_map && (wb_adr_i[5:0] == `OFS_CTRL0);
  wire wr_bufclr = wr && in_map && (wb_adr_i[5:0] == `OFS_BUFCLR);
  wire wr_alow = wr && in_map && (wb_adr_i[5:0] == `OFS_ADDR_LOW);
  wire wr_ahigh = wr && in_map && (wb_adr_i[5:0] == `OFS_ADDR_HIGH);
  wire wr_data = wr && in_map && (wb_adr_i[5:0] >= `OFS_DATA_BASE);
  wire [3:0] didx4 = widx - `IDX_DATA_BASE;
  wire [1:0] dword = didx4[2:1];
  wire dhigh = didx4[0];
  wire idle = (state == st_idle);

  ////////////////////////////////////////////////////////////////////////////
  // Unlock window and key check

  wire win_start = wr_ctrl && wbyte[`CTRL_TRIG_BIT] && !win_busy;
  wire [3:0] kidx4 = widx - `IDX_KEY_BASE;
  wire [2:0] kpos = kidx4[2:0];
  wire key_wr = wr_data && (widx >= `IDX_KEY_BASE) && win_busy && (mode == `MODE_UNLOCK);
  wire [7:0] key_exp = (kpos == 3'd0) ? `KEY_B0 :
                       (kpos == 3'd1) ? `KEY_B1 :
                       (kpos == 3'd2) ? `KEY_B2 :
                       (kpos == 3'd3) ? `KEY_B3 :
                       (kpos == 3'd4) ? `KEY_B4 : `KEY_B5;
  wire key_match = (wbyte == key_exp);
  wire key_done = win_busy && (&key_seen) && !key_bad;

  flash_op_timer #(
    .CYCLES(`UNLOCK_CYCLES)
  ) u_unlock_timer (
    .mclk(mclk),
    .rst(rst),
    .start(win_start),
    .busy(win_busy),
    .done()
  );

  always_ff @(posedge mclk) begin
    // A matched key is consumed at once so a later software clear of the enable sticks
    if (rst || win_start || !win_busy || key_done) begin
      key_seen <= 6'h00;
      key_bad <= 1'b0;
    end else if (key_wr) begin
      key_seen[kpos] <= 1'b1;
      if (!key_match) begin
        key_bad <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  wire [2:0] wmode = wbyte[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire launch_req = wr_ctrl && wbyte[`CTRL_START_BIT] && idle;
  wire launch_erase = launch_req && prog_en && (wmode == `MODE_ERASE);
  wire launch_write = launch_req && prog_en && (wmode == `MODE_WRITE);
  wire launch = launch_erase || launch_write;
  wire clr_req = wr_bufclr && wbyte[`BUFCLR_BIT] && idle && PAGE_VARIANT;

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode <= `RST_MODE;
      prog_en <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode <= wmode;
      end
      if (key_done) begin
        prog_en <= 1'b1;
      end else if (wr_ctrl && !wbyte[`CTRL_EN_BIT]) begin
        prog_en <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and data registers

  wire buf_load = PAGE_VARIANT && wr_data && (dword == 2'd0) && dhigh && idle;
  wire page_end = (addr_low[`PAGE_IDX_W-1:0] == {`PAGE_IDX_W{1'b1}});
  wire [5:0] ahigh_mask = PAGE_VARIANT ? 6'h3f : `SMALL_ADDR_HIGH_MASK;

  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_low <= `RST_BYTE;
      addr_high <= `RST_ADDR_HIGH;
    end else begin
      if (wr_alow) begin
        addr_low <= wbyte;
      end else if (buf_load && !page_end) begin
        addr_low <= addr_low + 8'h01;
      end
      if (wr_ahigh) begin
        addr_high <= wbyte[5:0] & ahigh_mask;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_data
      always_ff @(posedge mclk) begin
        if (rst) begin
          data_lo[gi] <= `RST_BYTE;
          data_hi[gi] <= `RST_BYTE;
        end else if (wr_data && (dword == 2'(gi))) begin
          if (dhigh) begin
            data_hi[gi] <= wbyte;
          end else begin
            data_lo[gi] <= wbyte;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Page write buffer

  wire [`ADDR_W-1:0] full_addr = {addr_high, addr_low};
  wire buf_we = buf_load || (state == st_clear);
  wire [`PAGE_IDX_W-1:0] buf_widx = (state == st_clear) ? op_cnt : addr_low[`PAGE_IDX_W-1:0];
  wire [15:0] buf_wdat = (state == st_clear) ? 16'h0000 : {wbyte, data_lo[0]};

  always_ff @(posedge mclk) begin
    if (buf_we) begin
      wbuf[buf_widx] <= buf_wdat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation sequencer

  flash_op_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_prog_timer (
    .mclk(mclk),
    .rst(rst),
    .start(launch),
    .busy(prog_busy),
    .done(prog_done)
  );

  wire [`PAGE_IDX_W-1:0] last_word = PAGE_VARIANT ? `PAGE_IDX_W'(`PAGE_WORDS - 1) :
                                     `PAGE_IDX_W'(`SMALL_WORDS - 1);
  wire walk_end = (op_cnt == last_word);
  wire [`ADDR_W-1:0] erase_addr = PAGE_VARIANT ?
    {full_addr[`ADDR_W-1:`PAGE_IDX_W], `PAGE_IDX_W'(0)} :
    {full_addr[`ADDR_W-1:8], 8'h00};
  wire [`ADDR_W-1:0] word_addr = PAGE_VARIANT ?
    {full_addr[`ADDR_W-1:`PAGE_IDX_W], op_cnt} :
    {full_addr[`ADDR_W-1:2], op_cnt[1:0]};
  wire [15:0] word_data = PAGE_VARIANT ? wbuf[op_cnt] :
    {data_hi[op_cnt[1:0]], data_lo[op_cnt[1:0]]};

  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (launch_erase) begin
          next_state = st_erase;
        end else if (launch_write) begin
          next_state = st_write;
        end else if (clr_req) begin
          next_state = st_clear;
        end
      end
      st_erase: begin
        next_state = st_wait;
      end
      st_write: begin
        if (walk_end) begin
          next_state = st_wait;
        end
      end
      st_wait: begin
        if (prog_done || !prog_busy) begin
          next_state = st_idle;
        end
      end
      st_clear: begin
        if (walk_end) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= st_idle;
      op_cnt <= '0;
      cpu_stall <= 1'b0;
      flash_erase <= 1'b0;
      flash_wr <= 1'b0;
      flash_addr <= '0;
      flash_wdata <= 16'h0000;
    end else begin
      state <= next_state;
      cpu_stall <= (next_state == st_erase) || (next_state == st_write)
        || (next_state == st_wait);
      op_cnt <= (state == next_state) ? op_cnt + `PAGE_IDX_W'(1) : '0;
      flash_erase <= (state == st_erase);
      flash_wr <= (state == st_write);
      flash_addr <= (state == st_erase) ? erase_addr : word_addr;
      flash_wdata <= word_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back and acknowledge

  wire [7:0] ctrl_rd = {prog_en, mode, win_busy, !idle && (state != st_clear), 2'b00};
  wire [7:0] data_rd = dhigh ? data_hi[dword] : data_lo[dword];
  wire [7:0] rd_byte = !in_map ? 8'h00 :
                       (wb_adr_i[5:0] == `OFS_CTRL0) ? ctrl_rd :
                       (wb_adr_i[5:0] == `OFS_BUFCLR) ? {7'h00, state == st_clear} :
                       (wb_adr_i[5:0] == `OFS_ADDR_LOW) ? addr_low :
                       (wb_adr_i[5:0] == `OFS_ADDR_HIGH) ? {2'b00, addr_high} : data_rd;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end
endmodule

`default_nettype wire

/* hdl/flash_seq_defines.svh */
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

// Register byte offsets on the bus
`define OFS_CTRL0 6'h00
`define OFS_BUFCLR 6'h04
`define OFS_ADDR_LOW 6'h08
`define OFS_ADDR_HIGH 6'h0c
`define OFS_DATA_BASE 6'h10
`define OFS_LAST 6'h2c

// Register word indices of data word 0 low and of the first key register (data word 1 low)
`define IDX_DATA_BASE 4'h4
`define IDX_KEY_BASE 4'h6

// control_reg0 field positions, and the buffer clear bit of the buffer clear register
`define CTRL_EN_BIT 7
`define CTRL_MODE_HI 6
`define CTRL_MODE_LO 4
`define CTRL_TRIG_BIT 3
`define CTRL_START_BIT 2
`define BUFCLR_BIT 0

// Operation mode codes
`define MODE_WRITE 3'h0
`define MODE_ERASE 3'h1
`define MODE_UNLOCK 3'h6

// Reset values
`define RST_BYTE 8'h00
`define RST_MODE 3'h0
`define RST_ADDR_HIGH 6'h00

// Unlock key, data word 1 low through data word 3 high
`define KEY_B0 8'h00
`define KEY_B1 8'h04
`define KEY_B2 8'h0d
`define KEY_B3 8'h09
`define KEY_B4 8'hc3
`define KEY_B5 8'h40

// Geometry
`define ADDR_W 14
`define PAGE_WORDS 64
`define PAGE_IDX_W 6
`define SMALL_WORDS 4
`define SMALL_ADDR_HIGH_MASK 6'h0f

// Timing
`define CLK_MHZ 100
`define PROG_TIME_US 2200
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`define UNLOCK_TIME_US 10
`define UNLOCK_CYCLES (`UNLOCK_TIME_US * `CLK_MHZ)

`endif

/* hdl/flash_seq_pkg.sv */
package flash_seq_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_erase,
    st_write,
    st_wait,
    st_clear
  } seq_state_e;

  typedef logic [2:0] op_mode_t;

endpackage

/* hdl/flash_op_timer.sv */
`timescale 1ns/1ns
`default_nettype none

// One-shot interval timer: busy for CYCLES clocks after start, then one done pulse
module flash_op_timer #(
  parameter int unsigned CYCLES = 1000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt;
  wire last = (cnt == W'(CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= '0;
    end else begin
      done <= busy && last;
      if (start && !busy) begin
        busy <= 1'b1;
        cnt <= '0;
      end else if (busy) begin
        busy <= !last;
        cnt <= cnt + W'(1);
      end
    end
  end
endmodule

`default_nettype wire

/* sim/flash_seq_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_defines.svh"
module flash_seq_asserts #(
  parameter bit PAGE_VARIANT = 1'b1,
  parameter int unsigned PROG_CYCLES = 200
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cpu_stall,
  input wire logic flash_erase,
  input wire logic flash_wr,
  input wire logic [`ADDR_W-1:0] flash_addr
);
  logic [17:0] run;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire ers_ok = PAGE_VARIANT ? flash_addr[5:0] == 6'h0 : flash_addr[7:0] == 8'h0;
  // Length of the current stall
  always_ff @(posedge mclk) begin
    if (rst || !cpu_stall) run <= '0;
    else run <= run + 18'h1;
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_ACK_NEXT: assert property (req |=> wb_ack_o)
    else $error("request not answered next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_UNMAPPED: assert property (req && wb_adr_i > 8'h2c |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_OP_STALL: assert property (flash_erase || flash_wr |-> cpu_stall)
    else $error("flash strobe outside stall");
  AST_ERASE_ONCE: assert property (flash_erase |=> !flash_erase [*8])
    else $error("erase strobe repeated");
  AST_ERASE_ALIGN: assert property (flash_erase |-> ers_ok)
    else $error("erase address not unit aligned");
  AST_WR_STEP: assert property (flash_wr && $past(flash_wr) |->
    flash_addr == $past(flash_addr) + 14'h1) else $error("write address not consecutive");
  AST_STALL_LEN: assert property ($fell(cpu_stall) |->
    run >= PROG_CYCLES - 2 && run <= PROG_CYCLES + 4) else $error("stall length wrong");
  AST_STALL_MAX: assert property (cpu_stall |-> run <= PROG_CYCLES + 4)
    else $error("stall too long");
endmodule
bind flash_program_erase_sequencer flash_seq_asserts #(
  .PAGE_VARIANT(PAGE_VARIANT), .PROG_CYCLES(PROG_CYCLES)
) chk (
  .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_stall(cpu_stall),
  .flash_erase(flash_erase), .flash_wr(flash_wr), .flash_addr(flash_addr)
);
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
  localparam int unsigned PROG = 200;
  logic mclk, rst, cyc, stb, we, ack, stall, fer, fwr;
  logic [7:0] adr, rd;
  logic [31:0] dat, rdat;
  logic [3:0] sel;
  logic [13:0] fadr, er_adr, wr_base;
  logic [15:0] fwd;
  logic [15:0] mem [64];
  int miscompares, cmp_count, n_er, n_wr, cycles;
  flash_program_erase_sequencer #(.PAGE_VARIANT(1'b1), .PROG_CYCLES(PROG)) dut (
    .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cpu_stall(stall), .flash_erase(fer), .flash_wr(fwr), .flash_addr(fadr),
    .flash_wdata(fwd)
  );
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Flash side monitor and run limit
  always @(posedge mclk) begin
    cycles++;
    if (fer === 1'b1) begin
      n_er++;
      er_adr = fadr;
      foreach (mem[i]) mem[i] = 16'h0000;
    end
    if (fwr === 1'b1) begin n_wr++; mem[fadr[5:0]] = fwd; wr_base = fadr & 14'h3fc0; end
    if (cycles == 12000) begin miscompares++; stop_test; end
  end
  ////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
    do @(posedge mclk); while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d); wb(1'b1, a, d); endtask
  task automatic rdr(input logic [7:0] a); wb(1'b0, a, 8'h0); endtask
  task automatic wait_op;
    while (stall === 1'b1) @(posedge mclk);
  endtask
  task automatic unlock(input logic [7:0] k5);
    wr(8'h00, 8'h68);
    wr(8'h18, 8'h00); wr(8'h1c, 8'h04); wr(8'h20, 8'h0d);
    wr(8'h24, 8'h09); wr(8'h28, 8'hc3); wr(8'h2c, k5);
  endtask
  task automatic t_regs;
    rdr(8'h00); `CHK(rd, 8'h00)
    rdr(8'h28); `CHK(rd, 8'h00)
    rdr(8'h2c); `CHK(rd, 8'h00)
    wr(8'h2c, 8'h5a); rdr(8'h2c); `CHK(rd, 8'h5a)
    wr(8'h30, 8'hff); rdr(8'h30); `CHK(rd, 8'h00)
  endtask
  task automatic t_locked;
    wr(8'h00, 8'h94); repeat (5) @(posedge mclk);
    `CHK(stall, 1'b0)
    `CHK(n_er, 0)
  endtask
  task automatic t_keys;
    unlock(8'h41); rdr(8'h00); `CHK(rd, 8'h68)
    repeat (1000) @(posedge mclk);
    rdr(8'h00); `CHK(rd, 8'h60)
    unlock(8'h40); rdr(8'h00); `CHK(rd[7], 1'b1)
    wr(8'h00, 8'h60); rdr(8'h00); `CHK(rd[7], 1'b0)
    unlock(8'h40); rdr(8'h00); `CHK(rd[7], 1'b1)
  endtask
  task automatic t_erase;
    int n;
    n = 0;
    wr(8'h0c, 8'h15); wr(8'h08, 8'h6b); wr(8'h00, 8'h94);
    `CHK(stall, 1'b1)
    while (stall === 1'b1) begin @(posedge mclk); n++; end
    `CHK(n > PROG - 6 && n < PROG + 4, 1'b1)
    `CHK(n_er, 1)
    `CHK(er_adr, 14'h1540)
    for (int k = 0; k < 64; k++) `CHK(mem[k], 16'h0000)
    rdr(8'h00); `CHK(rd[2], 1'b0)
  endtask
  task automatic t_page;
    wr(8'h08, 8'h40);
    for (int i = 0; i < 66; i++) begin
      wr(8'h10, i[7:0]); wr(8'h14, 8'ha5);
    end
    wr(8'h10, 8'hee); wr(8'h00, 8'h84); @(posedge mclk); wait_op;
    `CHK(n_wr, 64)
    `CHK(wr_base, 14'h1540)
    for (int k = 0; k < 63; k++) `CHK(mem[k], {8'ha5, k[7:0]})
    `CHK(mem[63], 16'ha541)
  endtask
  task automatic t_clear;
    wr(8'h04, 8'h01); rdr(8'h04); `CHK(rd, 8'h01)
    repeat (80) @(posedge mclk);
    rdr(8'h04); `CHK(rd, 8'h00)
    wr(8'h08, 8'h40); wr(8'h10, 8'h12); wr(8'h14, 8'h34);
    wr(8'h00, 8'h84); @(posedge mclk); wait_op;
    `CHK(n_wr, 128)
    `CHK(wr_base, 14'h1540)
    `CHK(mem[0], 16'h3412)
    `CHK(mem[1], 16'h0000)
    `CHK(mem[63], 16'h0000)
  endtask
  task automatic t_relock;
    wr(8'h00, 8'h00); rdr(8'h00); `CHK(rd[7], 1'b0)
    wr(8'h00, 8'h84); repeat (4) @(posedge mclk);
    `CHK(stall, 1'b0)
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h0; dat = 32'h0; sel = 4'h1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_regs; t_locked; t_keys; t_erase; t_page; t_clear; t_relock;
    stop_test;
  end
endmodule
`default_nettype wire
